/* logic/rx_status_pkg.sv */
// Shared constants for the receiver status word readout
package rx_status_pkg;

    // ************************************************************
    // Address and word layout
    // ************************************************************
    localparam logic [7:0] STATUS_ADDR = 8'hea;
    localparam int WORD_W = 24;
    localparam int NUM_INPUTS = 7;
    localparam int NUM_EVENTS = 5;

    // Bit positions in the status word
    localparam int POS_PRESENT = 0;
    localparam int POS_ERROR = 8;
    localparam int POS_EVENTS = 9;
    localparam int POS_NONPCM = 12;
    localparam int POS_EMPHASIS = 15;
    localparam int POS_TYPE_BIT = 16;
    localparam int POS_BURST = 17;
    localparam int POS_SYNC_5P1 = 18;
    localparam int POS_SYNC_6P1 = 19;

    // Event flag indices
    localparam int EV_INPUT_CHANGE = 0;
    localparam int EV_RATE = 1;
    localparam int EV_CHAN_STATUS = 2;
    localparam int EV_BURST_INFO = 3;
    localparam int EV_PARALLEL = 4;

    // Values after reset
    localparam logic [WORD_W-1:0] WORD_RESET = 24'h00_0000;
    localparam logic [NUM_INPUTS-1:0] PRESENT_RESET = 7'h00;
    localparam logic [NUM_EVENTS-1:0] EVENTS_RESET = 5'h00;

endpackage : rx_status_pkg

/* logic/sticky_flags.sv */
// Array of sticky event flags, cleared as a group, set wins over clear
`timescale 1ns/1ps
module sticky_flags #(
    parameter int N = 5
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Events and clear
    input wire logic [N-1:0] set_pulse,
    input wire logic clear,
    // Flag state
    output logic [N-1:0] flags_q
);

    // ************************************************************
    // Flag storage
    // ************************************************************
    // Refused at elaboration, so a bad width never reaches a netlist
    if (N < 1) begin : g_bad_n
        $error("sticky_flags needs at least one flag");
    end

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_flag
            // An event in the clearing cycle survives for the next read
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    flags_q[i] <= 1'b0;
                end else if (set_pulse[i]) begin
                    flags_q[i] <= 1'b1;
                end else if (clear) begin
                    flags_q[i] <= 1'b0;
                end
            end
        end
    endgenerate

endmodule : sticky_flags

/* logic/rx_input_detect_status_readout.sv */
// Status word readout: input presence, live status and clear-on-read events
// What this block does
// R1: Answers address input_detect_and_event_flags with 24-bit word
// R2: Bits 0..6 show per-input data presence
// R3: Bit 8 shows receive error at read
// R4: Error bit is live, never latched
// R5: Bit 9 flags input status change, clear-on-read
// R6: Bit 10 flags rate result update, clear-on-read
// R7: Bit 11 flags channel-status capture update, clear-on-read
// R8: Bit 12 shows live non-PCM detection
// R9: Bit 13 flags burst Pc update, clear-on-read
// R10: Bit 14 flags parallel input update, clear-on-read
// R11: Bit 16 mirrors channel-status bit 1
// R12: Bit 17 shows burst preamble Pa/Pb found
// R13: Bit 18 shows 5.1 stream sync found
// R14: Bit 19 shows 6.1 stream sync found
// R15: Error/non-PCM follow source select, not interrupt setup
// R16: Parallel update flag only in parallel-input mode
// R17: Bits 7 and 20..23 read zero
// R18: Flags clear at read completion; new events kept
`timescale 1ns/1ps
module rx_input_detect_status_readout #(
    parameter int NUM_INPUTS = rx_status_pkg::NUM_INPUTS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Read request from the control bus
    input wire logic rd_req,
    input wire logic [7:0] rd_addr,
    // Read answer
    output logic rd_valid_q,
    output logic [rx_status_pkg::WORD_W-1:0] rd_data_q,
    // Receiver status sources
    input wire logic [NUM_INPUTS-1:0] input_present,
    input wire logic error_source_select,
    input wire logic demod_error,
    input wire logic alt_error,
    input wire logic demod_nonpcm,
    input wire logic alt_nonpcm,
    input wire logic emphasis_status,
    input wire logic chan_status_type_bit,
    input wire logic burst_preamble_found,
    input wire logic surround_5p1_sync_found,
    input wire logic surround_6p1_sync_found,
    // Update strobes, one cycle each, then the pin function select level
    input wire logic rate_result_update,
    input wire logic chan_status_update,
    input wire logic burst_info_update,
    input wire logic parallel_input_update,
    input wire logic pin_function_select
);

    // ************************************************************
    // Parameter check
    // ************************************************************
    // The word layout has room for seven presence bits only
    if (NUM_INPUTS != rx_status_pkg::NUM_INPUTS) begin : g_bad_width
        $error("status word holds exactly seven presence bits");
    end

    // ************************************************************
    // Event detection
    // ************************************************************
    logic [NUM_INPUTS-1:0] present_prev_q;
    logic [rx_status_pkg::NUM_EVENTS-1:0] ev_set;
    logic [rx_status_pkg::NUM_EVENTS-1:0] flags_q;
    logic read_hit;
    logic live_error_status;
    logic live_nonpcm_status;

    // Only a read of our own address is answered
    assign read_hit = rd_req && (rd_addr == rx_status_pkg::STATUS_ADDR); // [R1]

    // Previous presence pattern, for change detection
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            present_prev_q <= rx_status_pkg::PRESENT_RESET;
        end else begin
            present_prev_q <= input_present;
        end
    end

    // Event strobes into the sticky flags
    always_comb begin
        ev_set = rx_status_pkg::EVENTS_RESET;
        ev_set[rx_status_pkg::EV_INPUT_CHANGE] = (input_present != present_prev_q); // [R5]
        ev_set[rx_status_pkg::EV_RATE] = rate_result_update; // [R6]
        ev_set[rx_status_pkg::EV_CHAN_STATUS] = chan_status_update; // [R7]
        ev_set[rx_status_pkg::EV_BURST_INFO] = burst_info_update; // [R9]
        // Selector-input mode has no parallel data to report
        ev_set[rx_status_pkg::EV_PARALLEL] = parallel_input_update && !pin_function_select; // [R10] [R16]
    end

    // Flags clear in the cycle the word is captured, set wins
    sticky_flags #(
        .N(rx_status_pkg::NUM_EVENTS)
    ) u_flags (
        .clk(clk),
        .rst_b(rst_b),
        .set_pulse(ev_set),
        .clear(read_hit), // [R18]
        .flags_q(flags_q)
    );

    // ************************************************************
    // Live status selection
    // ************************************************************
    // Two-way source pick, shared by the error and non-PCM bits
    function automatic logic pick_source(input logic sel, input logic main_src, input logic alt_src);
        return sel ? alt_src : main_src;
    endfunction : pick_source

    // Source select alone decides; interrupt pin setup plays no part
    assign live_error_status = pick_source(error_source_select, demod_error, alt_error); // [R15]
    assign live_nonpcm_status = pick_source(error_source_select, demod_nonpcm, alt_nonpcm); // [R15]

    // ************************************************************
    // Word assembly and answer
    // ************************************************************
    // Word captured at read time; all bits, live ones too, hold until the next read
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data_q <= rx_status_pkg::WORD_RESET;
        end else if (read_hit) begin
            rd_data_q <= rx_status_pkg::WORD_RESET; // [R17]
            rd_data_q[rx_status_pkg::POS_PRESENT +: NUM_INPUTS] <= input_present; // [R2]
            rd_data_q[rx_status_pkg::POS_ERROR] <= live_error_status; // [R3] [R4]
            rd_data_q[rx_status_pkg::POS_EVENTS +: 3] <= flags_q[2:0]; // [R5] [R6] [R7]
            rd_data_q[rx_status_pkg::POS_NONPCM] <= live_nonpcm_status; // [R8]
            rd_data_q[rx_status_pkg::POS_NONPCM + 1 +: 2] <= flags_q[4:3]; // [R9] [R10]
            rd_data_q[rx_status_pkg::POS_EMPHASIS] <= emphasis_status;
            rd_data_q[rx_status_pkg::POS_TYPE_BIT] <= chan_status_type_bit; // [R11]
            rd_data_q[rx_status_pkg::POS_BURST] <= burst_preamble_found; // [R12]
            rd_data_q[rx_status_pkg::POS_SYNC_5P1] <= surround_5p1_sync_found; // [R13]
            rd_data_q[rx_status_pkg::POS_SYNC_6P1] <= surround_6p1_sync_found; // [R14]
        end
    end

    // One-cycle answer strobe
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= read_hit; // [R1]
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    a_read_answered: assert property (@(posedge clk) disable iff (!rst_b) // [R1]
        read_hit |=> rd_valid_q)
        else $error("read of status address not answered");

    a_other_ignored: assert property (@(posedge clk) disable iff (!rst_b) // [R1]
        !read_hit |=> !rd_valid_q)
        else $error("answer without a status read");

    a_presence_bits: assert property (@(posedge clk) disable iff (!rst_b) // [R2]
        read_hit |=> rd_data_q[6:0] == $past(input_present))
        else $error("presence bits differ from inputs at read");

    a_error_live: assert property (@(posedge clk) disable iff (!rst_b) // [R4]
        read_hit |=> rd_data_q[8] == ($past(error_source_select) ? $past(alt_error) : $past(demod_error)))
        else $error("error bit not the live selected status");

    a_nonpcm_live: assert property (@(posedge clk) disable iff (!rst_b) // [R8]
        read_hit |=> rd_data_q[12] == ($past(error_source_select) ? $past(alt_nonpcm) : $past(demod_nonpcm)))
        else $error("non-PCM bit not the live selected status");

    a_change_sets: assert property (@(posedge clk) disable iff (!rst_b) // [R5]
        (input_present != $past(input_present)) ##1 read_hit |=> rd_data_q[9])
        else $error("input change not reported");

    a_rate_cleared: assert property (@(posedge clk) disable iff (!rst_b) // [R6]
        read_hit && !rate_result_update ##1 read_hit && !rate_result_update |=> !rd_data_q[10])
        else $error("rate flag not cleared by read");

    a_set_wins: assert property (@(posedge clk) disable iff (!rst_b) // [R18]
        read_hit && chan_status_update |=> flags_q[2])
        else $error("event lost during read");

    a_parallel_gated: assert property (@(posedge clk) disable iff (!rst_b) // [R16]
        pin_function_select && read_hit |=> !flags_q[4])
        else $error("parallel flag set in selector mode");

    a_unused_zero: assert property (@(posedge clk) disable iff (!rst_b) // [R17]
        rd_valid_q |-> rd_data_q[7] == 1'b0 && rd_data_q[23:20] == 4'h0)
        else $error("unused bits not zero");

    a_stream_bits: assert property (@(posedge clk) disable iff (!rst_b) // [R13]
        read_hit |=> rd_data_q[19:16] == {$past(surround_6p1_sync_found), $past(surround_5p1_sync_found),
            $past(burst_preamble_found), $past(chan_status_type_bit)})
        else $error("stream detection bits wrong");

    // Word must not move between reads, or the host could see a torn value
    a_word_holds: assert property (@(posedge clk) disable iff (!rst_b) // [R1]
        !read_hit |=> $stable(rd_data_q))
        else $error("status word changed without a read");

    a_error_select: assert property (@(posedge clk) disable iff (!rst_b) // [R3]
        read_hit && !error_source_select |=> rd_data_q[8] == $past(demod_error))
        else $error("error bit not taken from the demodulator");

    a_change_flag: assert property (@(posedge clk) disable iff (!rst_b) // [R5]
        (input_present != present_prev_q) |=> flags_q[0])
        else $error("input change not flagged");

    a_rate_sets: assert property (@(posedge clk) disable iff (!rst_b) // [R6]
        rate_result_update |=> flags_q[1])
        else $error("rate update not flagged");

    a_chan_sets: assert property (@(posedge clk) disable iff (!rst_b) // [R7]
        chan_status_update |=> flags_q[2])
        else $error("channel status update not flagged");

    a_burst_sets: assert property (@(posedge clk) disable iff (!rst_b) // [R9]
        burst_info_update |=> flags_q[3])
        else $error("burst info update not flagged");

    a_parallel_sets: assert property (@(posedge clk) disable iff (!rst_b) // [R10]
        parallel_input_update && !pin_function_select |=> flags_q[4])
        else $error("parallel update not flagged");

    // Only a read may drop a flag; anything else would lose an event
    a_flag_holds: assert property (@(posedge clk) disable iff (!rst_b) // [R18]
        !read_hit && flags_q[0] |=> flags_q[0])
        else $error("change flag dropped without a read");

endmodule : rx_input_detect_status_readout

/* tb/host_reader.sv */
// Host-side reader that issues status word reads
`timescale 1ns/1ps
module host_reader (
    // Clock
    input wire logic clk,
    // Read request
    output logic rd_req,
    output logic [7:0] rd_addr,
    // High while a read is in progress
    output logic busy
);
    // Idle bus at time zero
    initial begin
        rd_req = 1'b0;
        rd_addr = 8'h00;
        busy = 1'b0;
    end

    // Hold the request for n edges; a released address shows its inverse, never a stale copy
    task automatic read(input logic [7:0] a, input int n);
        busy = 1'b1;
        rd_req = 1'b1;
        rd_addr = a;
        repeat (n) @(posedge clk);
        #1;
        rd_req = 1'b0;
        rd_addr = ~a;
        @(posedge clk);
        #1;
        busy = 1'b0;
    endtask : read
endmodule : host_reader

/* tb/test_rx_input_detect_status_readout.sv */
// Self-checking bench for the status word readout
`timescale 1ns/1ps
module test_rx_input_detect_status_readout;
    // ****************************************
    // Signals and instances
    // ****************************************
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic rd_req, rd_valid_q, busy;
    logic [7:0] rd_addr;
    logic [rx_status_pkg::WORD_W-1:0] rd_data_q, w, e_m;
    logic [6:0] input_present, prev_m;
    logic error_source_select, demod_error, alt_error, demod_nonpcm, alt_nonpcm, emphasis_status;
    logic chan_status_type_bit, burst_preamble_found, surround_5p1_sync_found, surround_6p1_sync_found;
    logic rate_result_update, chan_status_update, burst_info_update, parallel_input_update, pin_function_select;
    logic [4:0] flags_m, ev;
    logic [23:0] notes[$];
    logic [31:0] lfsr_q = 32'hb07b;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;

    rx_input_detect_status_readout i_dut (
        .clk, .rst_b, .rd_req, .rd_addr, .rd_valid_q, .rd_data_q, .input_present, .error_source_select,
        .demod_error, .alt_error, .demod_nonpcm, .alt_nonpcm, .emphasis_status, .chan_status_type_bit,
        .burst_preamble_found, .surround_5p1_sync_found, .surround_6p1_sync_found, .rate_result_update,
        .chan_status_update, .burst_info_update, .parallel_input_update, .pin_function_select
    );
    host_reader i_host (.clk, .rd_req, .rd_addr, .busy);

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    // Sources from one random word; strobes need three bits so flags do not saturate
    task automatic drive_src(input logic [31:0] r);
        if (r[31:30] == 2'h0) input_present = r[6:0];
        error_source_select = r[7];
        demod_error = r[8];
        alt_error = r[9];
        demod_nonpcm = r[10];
        alt_nonpcm = r[11];
        emphasis_status = r[12];
        rate_result_update = &r[15:13];
        chan_status_update = &r[18:16];
        burst_info_update = &r[21:19];
        parallel_input_update = &r[24:22];
        chan_status_type_bit = r[25];
        burst_preamble_found = r[26];
        surround_5p1_sync_found = r[27];
        surround_6p1_sync_found = r[28];
        pin_function_select = r[29];
    endtask : drive_src

    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test

    // Reference flags kept at the same edges as the device; expected words noted at the taken edge
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flags_m = 5'h00;
            prev_m = 7'h00;
        end else begin
            ev = {parallel_input_update & ~pin_function_select, burst_info_update, chan_status_update,
                  rate_result_update, input_present != prev_m};
            if (rd_req && rd_addr == rx_status_pkg::STATUS_ADDR) begin
                w = 24'h00_0000;
                w[6:0] = input_present;
                w[8] = error_source_select ? alt_error : demod_error;
                w[11:9] = flags_m[2:0];
                w[12] = error_source_select ? alt_nonpcm : demod_nonpcm;
                w[14:13] = flags_m[4:3];
                w[15] = emphasis_status;
                w[19:16] = {surround_6p1_sync_found, surround_5p1_sync_found, burst_preamble_found,
                            chan_status_type_bit};
                notes.push_back(w);
                flags_m = ev;
            end else begin
                flags_m = flags_m | ev;
            end
            prev_m = input_present;
        end
    end

    // Each answer is matched against the oldest note, off the sampling edge
    always @(negedge clk) begin
        if (rd_valid_q === 1'b1) begin
            e_m = (notes.size() == 0) ? ~rd_data_q : notes.pop_front();
            chk(rd_data_q & 24'h00_007f, e_m & 24'h00_007f);
            chk(rd_data_q & 24'hf0_0080, e_m & 24'hf0_0080);
            chk(rd_data_q & 24'h00_1100, e_m & 24'h00_1100);
            chk(rd_data_q & 24'h00_6e00, e_m & 24'h00_6e00);
            chk(rd_data_q & 24'h0f_8000, e_m & 24'h0f_8000);
        end
    end

    // Clock and hang limit
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 8000) begin
            num_errors++;
            stop_test();
        end
    end

    initial begin
        drive_src(32'h0);
        input_present = 7'h00;
        repeat (2) @(posedge clk);
        #1;
        chk(rd_data_q, rx_status_pkg::WORD_RESET);
        rst_b = 1'b1;
        // Read at the first allowed edge, an unmapped address, then a back-to-back burst
        i_host.read(rx_status_pkg::STATUS_ADDR, 1);
        i_host.read(8'heb, 2);
        i_host.read(rx_status_pkg::STATUS_ADDR, 3);
        // Random traffic; reads overlap live changes and event strobes
        repeat (4000) begin
            lfsr_q = lfsr_next(lfsr_q);
            drive_src(lfsr_q);
            if (!busy && lfsr_q[2:0] == 3'h0) begin
                fork
                    i_host.read(lfsr_q[4] ? rx_status_pkg::STATUS_ADDR : lfsr_q[23:16], int'(lfsr_q[6:5]) + 1);
                join_none
            end
            @(posedge clk);
            #1;
        end
        wait (busy == 1'b0);
        repeat (3) @(posedge clk);
        chk(24'(notes.size()), 24'h00_0000);
        // Mid-run reset with inputs present: the first edge after release flags a change
        #1;
        drive_src(32'h0);
        input_present = 7'h55;
        rst_b = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk(rd_data_q, rx_status_pkg::WORD_RESET);
        rst_b = 1'b1;
        i_host.read(rx_status_pkg::STATUS_ADDR, 1);
        i_host.read(rx_status_pkg::STATUS_ADDR, 1);
        repeat (3) @(posedge clk);
        chk(24'(notes.size()), 24'h00_0000);
        stop_test();
    end
endmodule : test_rx_input_detect_status_readout
